// *** pkg/wts_map.svh ***
`ifndef WTS_MAP_SVH
`define WTS_MAP_SVH

// ------------------------------------------------------------------
// Register map, word addresses on the plain register port
// ------------------------------------------------------------------
`define WTS_REG_CTRL 4'h0
`define WTS_REG_STATUS 4'h1
`define WTS_REG_EVENT 4'h2
`define WTS_REG_CMD 4'h3

// ------------------------------------------------------------------
// Field values and positions
// ------------------------------------------------------------------
// Direction bit value that makes a pin a trigger output
`define WTS_DIR_OUT 1'b0
// Command register bit that issues a software sync
`define WTS_CMD_SYNC_BIT 0
// Reset value of synchronised pin levels
`define WTS_PIN_RST 1'b0
// Reset value of the edge detector history, blocks false edges
`define WTS_HIST_RST 1'b1
// Default geometry
`define WTS_NCH 4
`define WTS_AW 4
`define WTS_DW 16

`endif

// *** pkg/wts_pkg.sv ***
`default_nettype none

// ------------------------------------------------------------------
// Types shared by the trigger block
// ------------------------------------------------------------------
package wts_pkg;

    // Per-channel view of the waveform generator
    typedef struct packed {
        logic phase_zero;  // One-cycle pulse at phase 0
        logic phase_mid;   // One-cycle pulse at half period
        logic pulse_mode;  // Channel runs a pulse pattern
        logic pulse_level; // Current level of the pulse pattern
    } wts_gen_s;

    // Per-channel direction of the trigger pin
    typedef enum logic {
        WTS_PIN_OUT,
        WTS_PIN_IN
    } wts_dir_e;

endpackage

`default_nettype wire

// *** core/wts_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Two-flop synchroniser for asynchronous levels
// ------------------------------------------------------------------
module wts_sync2 #(
    parameter int W = 1,
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // First stage is read only by the second stage
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_r <= {W{RST_VAL}};
            sync_r <= {W{RST_VAL}};
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule // wts_sync2

`default_nettype wire

// *** core/wts_trigger.sv ***
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wts_map.svh"

module wts_trigger #(
    parameter int NCH = `WTS_NCH,
    parameter int AW = `WTS_AW,
    parameter int DW = `WTS_DW
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic driver_reset_low_i,
    // Register port
    input wire logic [AW-1:0] reg_addr_i,
    input wire logic [DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DW-1:0] reg_rdata_o,
    // Waveform generator side
    input wire wts_pkg::wts_gen_s [NCH-1:0] gen_i,
    output logic [NCH-1:0] restart_o,
    // Trigger pins and shared sync input
    input wire logic [NCH-1:0] channel_trigger_pin_i,
    output logic [NCH-1:0] channel_trigger_pin_o,
    output logic [NCH-1:0] channel_trigger_pin_oe_o,
    input wire logic sync_a_i
);

    // --------------------------------------------------------------
    // Input synchronisation
    // --------------------------------------------------------------
    localparam int SW = NCH + 2;

    logic [SW-1:0] pins_async;
    logic [SW-1:0] pins_sync;
    logic [NCH-1:0] pin_s;
    logic sync_s;
    logic drv_rst_low_s;
    logic rst_int;

    // Every asynchronous level shares one synchroniser bank
    assign pins_async = {driver_reset_low_i, sync_a_i, channel_trigger_pin_i};

    wts_sync2 #(
        .W(SW),
        .RST_VAL(`WTS_PIN_RST)
    ) wts_sync2_i (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(pins_async),
        .sync_o(pins_sync)
    );

    assign pin_s = pins_sync[NCH-1:0];
    assign sync_s = pins_sync[NCH];
    assign drv_rst_low_s = pins_sync[NCH+1];

    // Pin low or system reset; pin sync resets low so reset is held
    // until the pin is seen high after release
    assign rst_int = sys_rst_i | ~drv_rst_low_s;

    // --------------------------------------------------------------
    // Edge detection
    // --------------------------------------------------------------
    logic [NCH-1:0] pin_hist_r;
    logic sync_hist_r;
    logic [NCH-1:0] pin_rise;
    logic sync_rise;

    // History resets high so a level held through reset is no edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            pin_hist_r <= {NCH{`WTS_HIST_RST}};
            sync_hist_r <= `WTS_HIST_RST;
        end else begin
            pin_hist_r <= pin_s;
            sync_hist_r <= sync_s;
        end
    end

    // Only a low-to-high change counts, never a held level
    assign pin_rise = pin_s & ~pin_hist_r;
    assign sync_rise = sync_s & ~sync_hist_r;

    // --------------------------------------------------------------
    // Register decode
    // --------------------------------------------------------------
    logic wr_ctrl;
    logic wr_event;
    logic wr_cmd;
    logic rd_ctrl;
    logic rd_status;
    logic rd_event;
    logic soft_sync;

    // Plain address compare, no wait states
    assign wr_ctrl = reg_wr_i && (reg_addr_i == `WTS_REG_CTRL);
    assign wr_event = reg_wr_i && (reg_addr_i == `WTS_REG_EVENT);
    assign wr_cmd = reg_wr_i && (reg_addr_i == `WTS_REG_CMD);
    assign rd_ctrl = reg_rd_i && (reg_addr_i == `WTS_REG_CTRL);
    assign rd_status = reg_rd_i && (reg_addr_i == `WTS_REG_STATUS);
    assign rd_event = reg_rd_i && (reg_addr_i == `WTS_REG_EVENT);
    assign soft_sync = wr_cmd && reg_wdata_i[`WTS_CMD_SYNC_BIT];

    // --------------------------------------------------------------
    // Direction register
    // --------------------------------------------------------------
    logic [NCH-1:0] dir_r;
    logic [NCH-1:0] dir_nxt;

    assign dir_nxt = wr_ctrl ? reg_wdata_i[NCH-1:0] : dir_r;

    // All pins come up as trigger outputs
    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            dir_r <= {NCH{`WTS_DIR_OUT}};
        end else begin
            dir_r <= dir_nxt;
        end
    end

    // --------------------------------------------------------------
    // Restart generation
    // --------------------------------------------------------------
    logic [NCH-1:0] shared_req;
    logic [NCH-1:0] restart_nxt;
    logic [NCH-1:0] restart_r;

    // Shared sync and soft sync reach only output-mode channels
    assign shared_req = {NCH{sync_rise | soft_sync}} & ~dir_r;
    // Input-mode pins restart their own channel only
    assign restart_nxt = (pin_rise & dir_r) | shared_req;

    // One register for all channels keeps the restart aligned
    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            restart_r <= '0;
        end else begin
            restart_r <= restart_nxt;
        end
    end

    assign restart_o = restart_r;

    // --------------------------------------------------------------
    // Sticky restart flags
    // --------------------------------------------------------------
    logic [NCH-1:0] event_r;
    logic [NCH-1:0] event_clr;
    logic [NCH-1:0] event_nxt;

    // Write one to clear; a restart in the same cycle wins
    assign event_clr = wr_event ? reg_wdata_i[NCH-1:0] : '0;
    assign event_nxt = (event_r & ~event_clr) | restart_nxt;

    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            event_r <= '0;
        end else begin
            event_r <= event_nxt;
        end
    end

    // --------------------------------------------------------------
    // Trigger output per channel
    // --------------------------------------------------------------
    logic [NCH-1:0] trig_r;
    logic [NCH-1:0] trig_nxt;

    for (genvar ch = 0; ch < NCH; ch++) begin : g_trig
        wire logic set_hi;
        wire logic set_lo;

        assign set_hi = gen_i[ch].phase_zero;
        assign set_lo = gen_i[ch].phase_mid;

        // Pulse mode mirrors duty; otherwise zero sets, mid clears;
        // a set and a clear together resolve to high
        assign trig_nxt[ch] = gen_i[ch].pulse_mode ?
            gen_i[ch].pulse_level :
            (set_hi | (trig_r[ch] & ~set_lo));
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            trig_r <= '0;
        end else begin
            trig_r <= trig_nxt;
        end
    end

    // Pin n carries channel n; driven only in output mode
    assign channel_trigger_pin_o = trig_r & ~dir_r;
    assign channel_trigger_pin_oe_o = ~dir_r;

    // --------------------------------------------------------------
    // Read data
    // --------------------------------------------------------------
    localparam int STW = 2 * NCH + 2;

    logic [STW-1:0] status_word;
    logic [DW-1:0] rdata_nxt;
    logic [DW-1:0] rdata_r;

    // Live state: trigger levels, pin levels, sync and reset pins
    assign status_word = {drv_rst_low_s, sync_s, pin_s, trig_r};

    assign rdata_nxt =
        rd_ctrl ? DW'(dir_r) :
        rd_status ? DW'(status_word) :
        rd_event ? DW'(event_r) :
        '0;

    // Data stand for the one cycle after the read strobe
    always_ff @(posedge sys_clk_i) begin
        if (rst_int) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_int);

    sequence s_sync_rise;
        !sync_a_i ##1 sync_a_i;
    endsequence

    sequence s_dir_steady;
        $stable(dir_r) [*3];
    endsequence

    // All output-mode channels restart together after a sync edge
    a_sync_all_chan: assert property (
        s_sync_rise ##1 s_dir_steady |->
            ((restart_o & ~dir_r) == ~dir_r)
    ) else $error("sync edge did not restart all output channels");

    // An input-mode channel restarts only from its own pin
    a_sync_ignored: assert property (
        (restart_o & $past(dir_r) & ~$past(pin_rise)) == '0
    ) else $error("input-mode channel restarted without pin edge");

    // Pins come up as outputs whenever either reset ends
    a_reset_outputs: assert property (
        @(posedge sys_clk_i) disable iff (1'b0)
        $fell(rst_int) |->
            (channel_trigger_pin_oe_o == {NCH{1'b1}})
    ) else $error("pins not outputs after reset");

    // Reset pin low reaches the internal reset in two cycles
    a_pin_reset: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !driver_reset_low_i |-> ##2 rst_int ##1 (trig_r == '0)
    ) else $error("reset pin low did not reset block");

    for (genvar ch = 0; ch < NCH; ch++) begin : g_chk
        sequence s_pin_rise;
            !channel_trigger_pin_i[ch] ##1 channel_trigger_pin_i[ch];
        endsequence

        // Pin edge in input mode gives restart three cycles on
        a_pin_restart: assert property (
            s_pin_rise ##1 dir_r[ch] [*3] |-> restart_o[ch]
        ) else $error("pin edge did not restart channel");

        // A held high input level gives no restart
        a_held_high: assert property (
            (channel_trigger_pin_i[ch] && dir_r[ch]) [*5] |->
                !restart_o[ch]
        ) else $error("held pin level caused restart");

        // Phase zero drives the trigger high outside pulse mode
        a_trig_high: assert property (
            gen_i[ch].phase_zero && !gen_i[ch].pulse_mode |=>
                trig_r[ch]
        ) else $error("trigger not high after phase zero");

        // Mid period drives it low, and it is still low a cycle later if no phase zero follows
        a_trig_low: assert property (
            gen_i[ch].phase_mid && !gen_i[ch].phase_zero &&
            !gen_i[ch].pulse_mode ##1
            (!gen_i[ch].phase_zero && !gen_i[ch].pulse_mode) |->
                !trig_r[ch] [*2]
        ) else $error("trigger not low after mid period");

        // Pulse mode follows the pulse level one cycle later
        a_pulse_follow: assert property (
            gen_i[ch].pulse_mode |=>
                (trig_r[ch] == $past(gen_i[ch].pulse_level))
        ) else $error("trigger does not follow pulse duty");

        // Pin n shows channel n trigger while in output mode
        a_pin_map: assert property (
            !dir_r[ch] && $past(gen_i[ch].phase_zero) &&
            !$past(gen_i[ch].pulse_mode) && !$past(rst_int) |->
                channel_trigger_pin_o[ch] &&
                channel_trigger_pin_oe_o[ch]
        ) else $error("channel trigger not on its own pin");
    end

endmodule // wts_trigger

`default_nettype wire

// *** verif/wts_ext_trig.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// External trigger source facing the four trigger pins
// ------------------------------------------------------------
module wts_ext_trig (
    // Clock
    input wire logic sys_clk_i,
    // Block side of the pins
    input wire logic [3:0] pin_o_i,
    input wire logic [3:0] pin_oe_i,
    // Bench commands
    input wire logic [3:0] drv_en_i,
    input wire logic [3:0] drv_lvl_i,
    input wire logic sync_lvl_i,
    // Resolved wires
    output logic [3:0] pin_wire_o,
    output logic sync_a_o
);
    logic [3:0] flip_r = 4'h5;

    // Released lines wander, so a stale level is never mistaken for data
    always_ff @(posedge sys_clk_i) begin
        flip_r <= ~flip_r;
    end

    // Block drives while enabled, else this side, else nobody
    assign pin_wire_o = (pin_oe_i & pin_o_i)
        | (~pin_oe_i & drv_en_i & drv_lvl_i)
        | (~pin_oe_i & ~drv_en_i & flip_r);
    assign sync_a_o = sync_lvl_i;
endmodule // wts_ext_trig

`default_nettype wire

// *** verif/wts_trigger_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "wts_map.svh"

// Compare, count and report one value
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    fails++; $display("ERROR %s exp %h got %h", nm, exp, got); end end

module wts_trigger_bench;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic driver_reset_low = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    wts_pkg::wts_gen_s [3:0] gen = 16'h0000;
    logic [3:0] restart;
    logic [3:0] pin_wire;
    logic [3:0] pin_o;
    logic [3:0] pin_oe;
    logic [3:0] ext_lvl = 4'h0;
    logic sync_lvl = 1'b0;
    logic sync_a;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int pulses = 0;

    // ----------------------------------------
    // Clock, instances, watchdog
    // ----------------------------------------
    always #12.5 sys_clk_i = ~sys_clk_i;

    wts_trigger wts_trigger_i (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .driver_reset_low_i(driver_reset_low),
        .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .gen_i(gen), .restart_o(restart),
        .channel_trigger_pin_i(pin_wire), .channel_trigger_pin_o(pin_o),
        .channel_trigger_pin_oe_o(pin_oe), .sync_a_i(sync_a)
    );

    wts_ext_trig wts_ext_trig_i (
        .sys_clk_i(sys_clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
        .drv_en_i(4'hF), .drv_lvl_i(ext_lvl), .sync_lvl_i(sync_lvl),
        .pin_wire_o(pin_wire), .sync_a_o(sync_a)
    );

    // Restart pulses seen, to catch repeats from a held level
    always @(posedge sys_clk_i) begin
        cycles++;
        if (restart !== 4'h0) pulses++;
        if (cycles == 3000) begin
            fails++;
            close_out();
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
        input string nm);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
    endtask

    // One-cycle phase marker on one channel
    task automatic phase(input int ch, input logic mid);
        @(posedge sys_clk_i);
        if (mid) gen[ch].phase_mid <= 1'b1;
        else gen[ch].phase_zero <= 1'b1;
        @(posedge sys_clk_i);
        gen[ch].phase_zero <= 1'b0;
        gen[ch].phase_mid <= 1'b0;
        #1;
    endtask

    // Bounded wait for a restart, then it must drop
    task automatic wait_restart(input logic [3:0] e, input string nm);
        int n;
        n = 0;
        #1;
        while (restart === 4'h0 && n < 8) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        `CHK(nm, e, restart)
        @(posedge sys_clk_i);
        #1;
        `CHK(nm, 4'h0, restart)
    endtask

    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        #1;
        `CHK("pin_oe", 4'hF, pin_oe)
        `CHK("pin_o", 4'h0, pin_o)
        rd_chk(`WTS_REG_CTRL, 16'h0000, "ctrl");
        rd_chk(`WTS_REG_STATUS, 16'h0200, "status");
        for (int c = 0; c < 4; c++) begin
            phase(c, 1'b0);
            `CHK("trig_rise", 4'h1 << c, pin_o)
            phase(c, 1'b1);
            `CHK("trig_fall", 4'h0, pin_o)
        end
        // Pulse pattern ignores the half-period marker
        @(posedge sys_clk_i);
        gen[2].pulse_mode <= 1'b1;
        gen[2].pulse_level <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        `CHK("pulse_hi", 4'h4, pin_o)
        phase(2, 1'b1);
        `CHK("pulse_mid", 4'h4, pin_o)
        @(posedge sys_clk_i);
        gen[2].pulse_level <= 1'b0;
        @(posedge sys_clk_i);
        gen[2].pulse_mode <= 1'b0;
        #1;
        `CHK("pulse_lo", 4'h0, pin_o)
        // Shared sync, then held high
        sync_lvl <= 1'b1;
        wait_restart(4'hF, "sync_all");
        repeat (6) @(posedge sys_clk_i);
        `CHK("held_sync", 1, pulses)
        rd_chk(`WTS_REG_EVENT, 16'h000F, "event");
        wr_reg(`WTS_REG_EVENT, 16'h000F);
        rd_chk(`WTS_REG_EVENT, 16'h0000, "event_clr");
        sync_lvl <= 1'b0;
        // Channels 0 and 2 become inputs
        wr_reg(`WTS_REG_CTRL, 16'h0005);
        #1;
        `CHK("pin_oe_in", 4'hA, pin_oe)
        rd_chk(`WTS_REG_CTRL, 16'h0005, "ctrl_in");
        phase(0, 1'b0);
        `CHK("trig_in", 4'h0, pin_o)
        sync_lvl <= 1'b1;
        wait_restart(4'hA, "sync_part");
        ext_lvl <= 4'h4;
        wait_restart(4'h4, "pin_rise");
        repeat (6) @(posedge sys_clk_i);
        `CHK("held_pin", 3, pulses)
        rd_chk(`WTS_REG_STATUS, 16'h0341, "status_in");
        sync_lvl <= 1'b0;
        wr_reg(`WTS_REG_CMD, 16'h0001);
        wait_restart(4'hA, "soft_sync");
        rd_chk(4'hC, 16'h0000, "unmapped");
        // Reset pin low mid-run restores outputs
        driver_reset_low <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        #1;
        `CHK("pin_oe_rst", 4'hF, pin_oe)
        driver_reset_low <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        rd_chk(`WTS_REG_CTRL, 16'h0000, "ctrl_rst");
        close_out();
    end
endmodule // wts_trigger_bench

`default_nettype wire
